// File: common/gpio_pkg.sv
// constants, operation codes and register map of the parallel io port block
// Functional notes
// - port reads return pin levels, never latches
// - any reset sets every direction bit
// - first port has four bits, upper read zero
// - second port is a full eight bits
// - without third port, its address is storage
// - direction loaded only by direction op, unreadable
// - direction one tristates, zero drives latch
// - latches hold until the next port write
// - each pin direction set on its own
// - bit ops read pins, write whole latch
// - writes land at cycle end, reads sample start
// - latches unknown at power-on, kept across resets
package gpio_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int DATA_W   = 8;
   localparam int FILE_W   = 5;
   localparam int FIRST_W  = 4;
   localparam int BIT_IDX_W = 3;
   localparam int SYNC_STAGES = 3;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [FILE_W-1:0] FIRST_PORT_ADDR  = 5'h05;
   localparam logic [FILE_W-1:0] SECOND_PORT_ADDR = 5'h06;
   localparam logic [FILE_W-1:0] THIRD_PORT_ADDR  = 5'h07;

   localparam logic [DATA_W-1:0] DIR_RESET_VAL = 8'hff;
   localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;

   // ****************************************
   // cpu operations, one per instruction cycle
   // ****************************************
   typedef enum logic [2:0] {
      OP_NONE,
      OP_READ,
      OP_WRITE,
      OP_BIT_SET,
      OP_BIT_CLEAR,
      OP_DIR_LOAD
   } cpu_op_e;

endpackage : gpio_pkg

// File: common/port_ctl_if.sv
// carrier between the port controller and one port slice
`timescale 1ns/1ns
interface port_ctl_if #(parameter int W = 8);
   logic         wr_en;
   logic [W-1:0] wr_data;
   logic         dir_en;
   logic [W-1:0] dir_data;
   logic [W-1:0] latch;
   logic [W-1:0] dir;

   modport ctl   (output wr_en, wr_data, dir_en, dir_data, input latch, dir);
   modport slice (input wr_en, wr_data, dir_en, dir_data, output latch, dir);
endinterface : port_ctl_if

// File: hdl/pin_sync.sv
// three-stage pin synchroniser that accepts a bit once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // pins in, clean levels out
   input  wire logic [W-1:0] pin_in,
   output logic [W-1:0]      pin_level
);
   import gpio_pkg::*;

   logic [W-1:0] meta_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] agree;

   if (W < 1) begin : g_chk
      $error("pin_sync width must be at least one");
   end

   // only s2_ff looks at meta_ff
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         s2_ff   <= '0;
         s3_ff   <= '0;
      end else begin
         meta_ff <= pin_in;
         s2_ff   <= meta_ff;
         s3_ff   <= s2_ff;
      end
   end

   assign agree = ~(s2_ff ^ s3_ff);

   // a level is not latched by the port, so it counts only while still present
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_level <= '0;
      end else begin
         pin_level <= (s2_ff & agree) | (pin_level & ~agree);
      end
   end

endmodule : pin_sync

// File: hdl/port_slice.sv
// output latch and direction register of one port
`timescale 1ns/1ns
module port_slice #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // controller side
   port_ctl_if.slice ctl
);
   import gpio_pkg::*;

   if (W < 1 || W > DATA_W) begin : g_chk
      $error("port_slice width out of range");
   end

   // data latch has no reset: unknown at power-on, untouched by later resets
   always_ff @(posedge clk) begin
      if (ctl.wr_en) begin
         ctl.latch <= ctl.wr_data;
      end
   end

   // each bit is independent, a one disables the driver
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl.dir <= DIR_RESET_VAL[W-1:0];
      end else if (ctl.dir_en) begin
         ctl.dir <= ctl.dir_data;
      end
   end

endmodule : port_slice

// File: hdl/io_ports.sv
// parallel io ports: three ports behind the cpu file access, with pin drivers
`timescale 1ns/1ns
module io_ports #(
   parameter bit HAS_THIRD_PORT = 1'b1
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   // cpu file access
   input  wire gpio_pkg::cpu_op_e          op,
   input  wire logic [gpio_pkg::FILE_W-1:0] file_addr,
   input  wire logic [gpio_pkg::DATA_W-1:0] w_data,
   input  wire logic [gpio_pkg::BIT_IDX_W-1:0] bit_idx,
   output logic [gpio_pkg::DATA_W-1:0]     rd_data,
   output logic                            rd_hit,
   // first port pins
   input  wire logic [gpio_pkg::FIRST_W-1:0] first_pin_in,
   output logic [gpio_pkg::FIRST_W-1:0]    first_pin_out,
   output logic [gpio_pkg::FIRST_W-1:0]    first_pin_oe_b,
   // second port pins
   input  wire logic [gpio_pkg::DATA_W-1:0] second_pin_in,
   output logic [gpio_pkg::DATA_W-1:0]     second_pin_out,
   output logic [gpio_pkg::DATA_W-1:0]     second_pin_oe_b,
   // third port pins
   input  wire logic [gpio_pkg::DATA_W-1:0] third_pin_in,
   output logic [gpio_pkg::DATA_W-1:0]     third_pin_out,
   output logic [gpio_pkg::DATA_W-1:0]     third_pin_oe_b
);
   import gpio_pkg::*;

   // ****************************************
   // decode
   // ****************************************
   logic sel_first;
   logic sel_second;
   logic sel_third;
   logic is_bit_op;
   logic is_store_op;
   logic is_dir_op;

   assign sel_first   = (file_addr == FIRST_PORT_ADDR);
   assign sel_second  = (file_addr == SECOND_PORT_ADDR);
   assign sel_third   = (file_addr == THIRD_PORT_ADDR);
   assign is_bit_op   = (op == OP_BIT_SET) || (op == OP_BIT_CLEAR);
   assign is_store_op = (op == OP_WRITE) || is_bit_op;
   assign is_dir_op   = (op == OP_DIR_LOAD);

   // ****************************************
   // pin synchronisers and port slices
   // ****************************************
   logic [FIRST_W-1:0] first_level;
   logic [DATA_W-1:0]  second_level;
   logic [DATA_W-1:0]  third_level;

   pin_sync #(.W(FIRST_W)) u_first_sync (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_in    (first_pin_in),
      .pin_level (first_level)
   );

   pin_sync #(.W(DATA_W)) u_second_sync (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_in    (second_pin_in),
      .pin_level (second_level)
   );

   pin_sync #(.W(DATA_W)) u_third_sync (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_in    (third_pin_in),
      .pin_level (third_level)
   );

   port_ctl_if #(.W(FIRST_W)) first_ctl ();
   port_ctl_if #(.W(DATA_W))  second_ctl ();
   port_ctl_if #(.W(DATA_W))  third_ctl ();

   port_slice #(.W(FIRST_W)) u_first (
      .clk   (clk),
      .rst_b (rst_b),
      .ctl   (first_ctl.slice)
   );

   port_slice #(.W(DATA_W)) u_second (
      .clk   (clk),
      .rst_b (rst_b),
      .ctl   (second_ctl.slice)
   );

   port_slice #(.W(DATA_W)) u_third (
      .clk   (clk),
      .rst_b (rst_b),
      .ctl   (third_ctl.slice)
   );

   // ****************************************
   // read source per address
   // ****************************************
   // storage variant reads back its own byte, since no pins stand behind it
   logic [DATA_W-1:0] first_view;
   logic [DATA_W-1:0] second_view;
   logic [DATA_W-1:0] third_view;

   assign first_view  = {{(DATA_W-FIRST_W){1'b0}}, first_level};
   assign second_view = second_level;
   assign third_view  = HAS_THIRD_PORT ? third_level : third_ctl.latch;

   // ****************************************
   // bit set / clear: read pins, modify, write all
   // ****************************************
   logic [DATA_W-1:0] bit_mask;
   logic [DATA_W-1:0] base_view;
   logic [DATA_W-1:0] modified;

   assign bit_mask = DATA_W'(1) << bit_idx;

   always_comb begin
      base_view = ZERO_BYTE;
      if (sel_first) begin
         base_view = first_view;
      end else if (sel_second) begin
         base_view = second_view;
      end else if (sel_third) begin
         base_view = third_view;
      end
   end

   // input pins get their current level written back into their latches
   always_comb begin
      if (op == OP_BIT_SET) begin
         modified = base_view | bit_mask;
      end else if (op == OP_BIT_CLEAR) begin
         modified = base_view & ~bit_mask;
      end else begin
         modified = w_data;
      end
   end

   // ****************************************
   // slice control
   // ****************************************
   // the store lands on the edge that ends the instruction cycle
   assign first_ctl.wr_en    = is_store_op && sel_first;
   assign first_ctl.wr_data  = modified[FIRST_W-1:0];
   assign second_ctl.wr_en   = is_store_op && sel_second;
   assign second_ctl.wr_data = modified;
   assign third_ctl.wr_en    = is_store_op && sel_third;
   assign third_ctl.wr_data  = modified;

   // direction is only reachable through the direction-load operation
   assign first_ctl.dir_en    = is_dir_op && sel_first;
   assign first_ctl.dir_data  = w_data[FIRST_W-1:0];
   assign second_ctl.dir_en   = is_dir_op && sel_second;
   assign second_ctl.dir_data = w_data;
   assign third_ctl.dir_en    = is_dir_op && sel_third && HAS_THIRD_PORT;
   assign third_ctl.dir_data  = w_data;

   // ****************************************
   // read answer
   // ****************************************
   // pins are sampled at the start of the cycle; direction is never readable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= ZERO_BYTE;
         rd_hit  <= 1'b0;
      end else if (op == OP_READ) begin
         rd_hit <= sel_first || sel_second || sel_third;
         if (sel_first) begin
            rd_data <= first_view;
         end else if (sel_second) begin
            rd_data <= second_view;
         end else if (sel_third) begin
            rd_data <= third_view;
         end else begin
            rd_data <= ZERO_BYTE;
         end
      end else begin
         rd_hit <= 1'b0;
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************
   // a driven pin is never reported as its latch, only as what the pad sees
   assign first_pin_out   = first_ctl.latch;
   assign first_pin_oe_b  = first_ctl.dir;
   assign second_pin_out  = second_ctl.latch;
   assign second_pin_oe_b = second_ctl.dir;
   assign third_pin_out   = HAS_THIRD_PORT ? third_ctl.latch : ZERO_BYTE;
   assign third_pin_oe_b  = HAS_THIRD_PORT ? third_ctl.dir : DIR_RESET_VAL;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic dir_loaded_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dir_loaded_ff <= 1'b0;
      end else if (is_dir_op) begin
         dir_loaded_ff <= 1'b1;
      end
   end

   a_read_pins_b: assert property (
      (op == OP_READ) && sel_second |=> rd_data == $past(second_level) && rd_hit)
      else $error("second port read did not return pin levels");

   a_first_upper_zero: assert property (
      (op == OP_READ) && sel_first |=> rd_data[DATA_W-1:FIRST_W] == '0)
      else $error("first port upper bits not zero");

   a_reset_dir_set: assert property (
      !dir_loaded_ff |-> (&second_pin_oe_b) && (&first_pin_oe_b) && (&third_pin_oe_b))
      else $error("direction not all ones before any load");

   a_dir_load_b: assert property (
      is_dir_op && sel_second |=> second_pin_oe_b == $past(w_data))
      else $error("direction load on second port not applied");

   a_latch_hold_b: assert property (
      !(is_store_op && sel_second) |=> $stable(second_pin_out))
      else $error("second port latch changed without a write");

   a_write_input_b: assert property (
      (op == OP_WRITE) && sel_second |=> second_pin_out == $past(w_data))
      else $error("write did not load second port latch");

   a_bit_set_b: assert property (
      (op == OP_BIT_SET) && sel_second
      |=> second_pin_out == ($past(second_level) | (DATA_W'(1) << $past(bit_idx))))
      else $error("bit set did not rewrite from pin levels");

   a_bit_clear_a: assert property (
      (op == OP_BIT_CLEAR) && sel_first
      |=> first_pin_out == ($past(first_level) & ~(FIRST_W'(1) << $past(bit_idx))))
      else $error("bit clear did not rewrite from pin levels");

   a_driver_follow_b: assert property (
      (op == OP_WRITE) && sel_second ##1 (op == OP_DIR_LOAD) && sel_second
      |=> second_pin_oe_b == $past(w_data) && second_pin_out == $past(w_data, 2))
      else $error("second port driver does not follow latch and direction");

   if (!HAS_THIRD_PORT) begin : g_store_chk
      a_store_third: assert property (
         (op == OP_WRITE) && sel_third ##1 (op == OP_READ) && sel_third
         |=> rd_data == $past(w_data, 2))
         else $error("third address does not act as storage");
   end

endmodule : io_ports

// File: sim/pin_model.sv
// far-side circuitry on one port: pull-ups plus a level driver steered by the bench
`timescale 1ns/1ns
module pin_model #(
   parameter int W = 8
) (
   // device side
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe_b,
   // bench steering
   input  wire logic [W-1:0] ext_val,
   input  wire logic [W-1:0] ext_en,
   // resolved pad level
   output logic [W-1:0]      pad
);
   // ****************************************
   // pad resolution
   // ****************************************
   // a pin left by both sides floats up to the pull-up, never to the last value
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!pin_oe_b[i]) begin
            pad[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pad[i] = ext_val[i];
         end else begin
            pad[i] = 1'b1;
         end
      end
   end
endmodule : pin_model

// File: sim/parallel_io_ports_tb_top.sv
// self-checking bench for the parallel io port block
`timescale 1ns/1ns
module parallel_io_ports_tb_top;
   import gpio_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic                 clk;
   logic                 rst_b;
   cpu_op_e              op;
   logic [FILE_W-1:0]    file_addr;
   logic [DATA_W-1:0]    w_data;
   logic [BIT_IDX_W-1:0] bit_idx;
   logic [DATA_W-1:0]    rd_data;
   logic [DATA_W-1:0]    rd_data_st;
   logic                 rd_hit;
   logic [FIRST_W-1:0]   a_out, a_oe_b, a_pad, a_ext, a_en;
   logic [DATA_W-1:0]    b_out, b_oe_b, b_pad, b_ext, b_en;
   logic [DATA_W-1:0]    c_out, c_oe_b, c_pad, c_ext, c_oe_b_st, c_en, c_out_st;
   int                   fails;
   int                   check_count;

   io_ports #(.HAS_THIRD_PORT(1'b1)) io_ports_inst (
      .clk(clk), .rst_b(rst_b), .op(op), .file_addr(file_addr), .w_data(w_data),
      .bit_idx(bit_idx), .rd_data(rd_data), .rd_hit(rd_hit),
      .first_pin_in(a_pad), .first_pin_out(a_out), .first_pin_oe_b(a_oe_b),
      .second_pin_in(b_pad), .second_pin_out(b_out), .second_pin_oe_b(b_oe_b),
      .third_pin_in(c_pad), .third_pin_out(c_out), .third_pin_oe_b(c_oe_b));
   // variant whose third address is plain storage
   io_ports #(.HAS_THIRD_PORT(1'b0)) io_ports_st_inst (
      .clk(clk), .rst_b(rst_b), .op(op), .file_addr(file_addr), .w_data(w_data),
      .bit_idx(bit_idx), .rd_data(rd_data_st), .rd_hit(),
      .first_pin_in(a_pad), .first_pin_out(), .first_pin_oe_b(),
      .second_pin_in(b_pad), .second_pin_out(), .second_pin_oe_b(),
      .third_pin_in(c_pad), .third_pin_out(c_out_st), .third_pin_oe_b(c_oe_b_st));
   // outside drivers let go of a pin before the device starts driving it
   pin_model #(.W(FIRST_W)) pin_model_a_inst (.pin_out(a_out), .pin_oe_b(a_oe_b),
      .ext_val(a_ext), .ext_en(a_en), .pad(a_pad));
   // two top pins of the second port rely on pull-ups only
   pin_model #(.W(DATA_W)) pin_model_b_inst (.pin_out(b_out), .pin_oe_b(b_oe_b),
      .ext_val(b_ext), .ext_en(b_en), .pad(b_pad));
   pin_model #(.W(DATA_W)) pin_model_c_inst (.pin_out(c_out), .pin_oe_b(c_oe_b),
      .ext_val(c_ext), .ext_en(c_en), .pad(c_pad));

   always #5 clk = ~clk;

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one op taken at the second edge, outputs looked at just after it
   task automatic cpu(input cpu_op_e o, input logic [4:0] a, input logic [7:0] w,
                      input logic [2:0] i);
      @(posedge clk);
      op <= o;
      file_addr <= a;
      w_data <= w;
      bit_idx <= i;
      @(posedge clk);
      op <= OP_NONE;
      #1;
   endtask : cpu

   // two ops on consecutive edges, outputs looked at just after the second
   task automatic cpu2(input cpu_op_e o1, input logic [4:0] a1, input logic [7:0] w1,
                       input cpu_op_e o2, input logic [4:0] a2, input logic [7:0] w2);
      @(posedge clk);
      op <= o1;
      file_addr <= a1;
      w_data <= w1;
      @(posedge clk);
      op <= o2;
      file_addr <= a2;
      w_data <= w2;
      @(posedge clk);
      op <= OP_NONE;
      #1;
   endtask : cpu2

   // pin levels reach reads only after the synchroniser
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask : settle

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   // ****************************************
   // tests
   // ****************************************
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      op = OP_NONE;
      file_addr = '0;
      w_data = '0;
      bit_idx = '0;
      a_ext = 4'ha;
      b_ext = 8'h3c;
      c_ext = 8'h5a;
      a_en = 4'hf;
      b_en = 8'h3f;
      c_en = 8'hff;
      fails = 0;
      check_count = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      check({4'h0, a_oe_b}, 8'h0f);
      check(b_oe_b, 8'hff);
      check(c_oe_b, 8'hff);
      $display("test reset done");
      settle();
      cpu(OP_READ, 5'h05, 8'h00, 3'h0);
      check(rd_data, 8'h0a);
      cpu(OP_READ, 5'h06, 8'h00, 3'h0);
      check(rd_data, 8'hfc);
      check({7'h0, rd_hit}, 8'h01);
      cpu(OP_READ, 5'h07, 8'h00, 3'h0);
      check(rd_data, 8'h5a);
      cpu(OP_READ, 5'h08, 8'h00, 3'h0);
      check({7'h0, rd_hit}, 8'h00);
      check(rd_data, 8'h00);
      $display("test pin reads done");
      cpu(OP_WRITE, 5'h06, 8'ha5, 3'h0);
      check(b_out, 8'ha5);
      check(b_oe_b, 8'hff);
      settle();
      cpu(OP_READ, 5'h06, 8'h00, 3'h0);
      check(rd_data, 8'hfc);
      // upper nibble is about to be driven, so the outside lets go of it
      @(posedge clk);
      b_en <= 8'h0f;
      cpu(OP_DIR_LOAD, 5'h06, 8'h0f, 3'h0);
      check(b_oe_b, 8'h0f);
      settle();
      cpu(OP_READ, 5'h06, 8'h00, 3'h0);
      check(rd_data, 8'hac);
      @(posedge clk);
      a_en <= 4'h0;
      cpu(OP_WRITE, 5'h05, 8'hff, 3'h0);
      cpu(OP_DIR_LOAD, 5'h05, 8'h00, 3'h0);
      check({4'h0, a_oe_b}, 8'h00);
      settle();
      cpu(OP_READ, 5'h05, 8'h00, 3'h0);
      check(rd_data, 8'h0f);
      check(b_out, 8'ha5);
      cpu(OP_BIT_CLEAR, 5'h05, 8'h00, 3'h2);
      check({4'h0, a_out}, 8'h0b);
      $display("test latch and direction done");
      cpu(OP_BIT_SET, 5'h06, 8'h00, 3'h1);
      check(b_out, 8'hae);
      settle();
      // low nibble inputs read c, so the e left by the set is overwritten
      cpu(OP_BIT_CLEAR, 5'h06, 8'h00, 3'h7);
      check(b_out, 8'h2c);
      @(posedge clk);
      b_en <= 8'h00;
      cpu(OP_DIR_LOAD, 5'h06, 8'h00, 3'h0);
      settle();
      cpu(OP_WRITE, 5'h06, 8'h4e, 3'h0);
      cpu(OP_READ, 5'h06, 8'h00, 3'h0);
      check(rd_data, 8'h2c);
      settle();
      cpu(OP_READ, 5'h06, 8'h00, 3'h0);
      check(rd_data, 8'h4e);
      cpu2(OP_WRITE, 5'h06, 8'h93, OP_DIR_LOAD, 5'h06, 8'h00);
      check(b_out, 8'h93);
      $display("test bit ops and timing done");
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      check(b_out, 8'h93);
      check({4'h0, a_out}, 8'h0b);
      check(b_oe_b, 8'hff);
      $display("test second reset done");
      cpu2(OP_WRITE, 5'h07, 8'hc3, OP_READ, 5'h07, 8'h00);
      check(rd_data_st, 8'hc3);
      check(c_out, 8'hc3);
      check(c_out_st, 8'h00);
      @(posedge clk);
      c_en <= 8'h00;
      cpu(OP_DIR_LOAD, 5'h07, 8'h00, 3'h0);
      check(c_oe_b_st, 8'hff);
      check(c_oe_b, 8'h00);
      settle();
      cpu(OP_READ, 5'h07, 8'h00, 3'h0);
      check(rd_data, 8'hc3);
      $display("test third address done");
      results();
   end

   // the tests need about 100 cycles; twenty times that means a hang
   initial begin
      repeat (2000) @(posedge clk);
      fails++;
      results();
   end
endmodule : parallel_io_ports_tb_top
